// ==== src/fcc_ctrl.sv ====
// Purpose: Switch on/off control of a flyback capacitor charger
// Assumes: Comparator outputs and pins are asynchronous levels
// Notes:   Switch output decodes the state flops only; all inputs but nrst and clk_en pass fcc_sync first
`timescale 1ns/1ps
`default_nettype none
module fcc_ctrl #(
  parameter int TOFF_MIN_CYC  = fcc_pkg::TOFF_MIN_CYC,
  parameter int TIMER_OFF_CYC = fcc_pkg::TIMER_OFF_CYC,
  parameter int CNT_W         = fcc_pkg::OFF_CNT_W
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic       charge_req,
  input  wire logic       current_limit_hit,
  input  wire logic       switch_node_low,
  input  wire logic       feedback_sense,
  input  wire logic       vout_above_mode,
  input  wire logic       current_limit_select_low,
  input  wire logic       current_limit_select_high,
  output logic            switch_on,
  output logic [1:0]      switch_current_limit,
  output logic            charging,
  output logic            timer_mode,
  output logic            charge_done
);

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  logic [6:0] raw_in;
  logic [6:0] sync_in;
  logic       req_s;
  logic       current_limit_select_hit_s;
  logic       sw_low_s;
  logic       fb_s;
  logic       vout_hi_s;
  logic       sel_low_s;
  logic       sel_high_s;

  assign raw_in = {charge_req, current_limit_hit, switch_node_low, feedback_sense,
                   vout_above_mode, current_limit_select_low, current_limit_select_high};

  fcc_sync #(.W(7)) fcc_sync_i (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  assign {req_s, current_limit_select_hit_s, sw_low_s, fb_s, vout_hi_s, sel_low_s, sel_high_s} = sync_in;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Three-level pin decode; both sensed is treated as floating
  function automatic logic [1:0] decode_limit(input logic lo, input logic hi);
    if (lo && !hi) begin
      decode_limit = fcc_pkg::LIM_1A6;
    end else if (hi && !lo) begin
      decode_limit = fcc_pkg::LIM_2A0;
    end else begin
      decode_limit = fcc_pkg::LIM_1A8;
    end
  endfunction

  localparam logic [CNT_W-1:0] MIN_LAST   = CNT_W'(TOFF_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] TIMER_LAST = CNT_W'(TIMER_OFF_CYC - 1);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  fcc_pkg::fcc_state_t state_q;
  fcc_pkg::fcc_state_t state_d;
  logic [CNT_W-1:0]    off_cnt_q;
  logic [CNT_W-1:0]    off_cnt_d;
  logic                req_prev_q;
  logic                req_prev_d;
  logic [1:0]          lim_q;
  logic [1:0]          lim_d;
  logic                tmode_q;
  logic                tmode_d;
  logic                req_rise;
  logic                fast_mode;
  logic [1:0]          lim_code;

  assign req_rise  = req_s && !req_prev_q;
  assign fast_mode = vout_hi_s;
  assign lim_code  = decode_limit(sel_low_s, sel_high_s);

  // Next state, off-time counter and latched limit
  always_comb begin
    state_d    = state_q;
    off_cnt_d  = off_cnt_q;
    lim_d      = lim_q;
    req_prev_d = req_s;
    tmode_d    = tmode_q;
    if (!clk_en) begin
      req_prev_d = req_prev_q;
    end else if (!req_s) begin
      state_d   = fcc_pkg::ST_IDLE;
      off_cnt_d = '0;
      tmode_d   = 1'b0;
    end else begin
      tmode_d = !fast_mode;
      unique case (state_q)
        fcc_pkg::ST_IDLE: begin
          if (req_rise) begin
            state_d = fcc_pkg::ST_ON;
            lim_d   = lim_code;
          end
        end
        fcc_pkg::ST_ON: begin
          off_cnt_d = '0;
          if (current_limit_select_hit_s) begin
            state_d = fcc_pkg::ST_OFF_MIN;
          end
        end
        fcc_pkg::ST_OFF_MIN: begin
          off_cnt_d = off_cnt_q + 1'b1;
          if (fb_s) begin
            state_d = fcc_pkg::ST_DONE;
          end else if (off_cnt_q >= MIN_LAST) begin
            state_d = fcc_pkg::ST_OFF_WAIT;
          end
        end
        fcc_pkg::ST_OFF_WAIT: begin
          if (off_cnt_q != {CNT_W{1'b1}}) begin
            off_cnt_d = off_cnt_q + 1'b1;
          end
          if (fb_s) begin
            state_d = fcc_pkg::ST_DONE;
          end else if (fast_mode && sw_low_s) begin
            state_d = fcc_pkg::ST_ON;
            lim_d   = lim_code;
          end else if (!fast_mode && off_cnt_q >= TIMER_LAST) begin
            state_d = fcc_pkg::ST_ON;
            lim_d   = lim_code;
          end
        end
        fcc_pkg::ST_DONE: begin
          off_cnt_d = '0;
          if (req_rise) begin
            state_d = fcc_pkg::ST_ON;
            lim_d   = lim_code;
          end
        end
        default: begin
          state_d = fcc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Register state
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q    <= fcc_pkg::ST_IDLE;
      off_cnt_q  <= '0;
      req_prev_q <= 1'b0;
      lim_q      <= fcc_pkg::LIM_1A8;
      tmode_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      off_cnt_q  <= off_cnt_d;
      req_prev_q <= req_prev_d;
      lim_q      <= lim_d;
      tmode_q    <= tmode_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flops
  // ---------------------------------------------------------------
  assign switch_on            = (state_q == fcc_pkg::ST_ON);
  assign switch_current_limit = lim_q;
  assign charging             = (state_q == fcc_pkg::ST_ON) ||
                                (state_q == fcc_pkg::ST_OFF_MIN) ||
                                (state_q == fcc_pkg::ST_OFF_WAIT);
  assign timer_mode           = tmode_q;
  assign charge_done          = (state_q == fcc_pkg::ST_DONE);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Off-time length of the period that just ended
  logic [CNT_W-1:0] off_len_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst || switch_on) begin
      off_len_q <= '0;
    end else if (clk_en && off_len_q != {CNT_W{1'b1}}) begin
      off_len_q <= off_len_q + 1'b1;
    end
  end

  sequence s_active_step;
    clk_en && req_s;
  endsequence

  sequence s_limit_trip;
    s_active_step and (switch_on && current_limit_select_hit_s);
  endsequence

  a_start_on_rise: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_active_step and (state_q == fcc_pkg::ST_IDLE) |-> ##1 (switch_on == $past(req_rise)))
    else $error("charge start not tied to request rise");

  a_limit_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_limit_trip |-> ##1 !switch_on ##1 (!switch_on || !clk_en || !req_s || off_len_q != 0))
    else $error("switch stayed on after current limit");

  a_fb_ignored_on: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_active_step and (switch_on && fb_s && !current_limit_select_hit_s) |-> ##1 switch_on)
    else $error("feedback acted during on-time");

  a_done_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
    charge_done && !req_rise |-> ##1 !switch_on)
    else $error("switch turned on after target without new request");

  a_fast_turn_on: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_active_step and ((state_q == fcc_pkg::ST_OFF_WAIT) && fast_mode && sw_low_s && !fb_s)
    |-> ##1 switch_on)
    else $error("fast mode did not turn on at low switch node");

  a_timer_no_early: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_active_step and ((state_q == fcc_pkg::ST_OFF_WAIT) && !fast_mode &&
    off_cnt_q < TIMER_LAST) |-> ##1 !switch_on)
    else $error("timer mode turned on before off-time end");

  a_timer_expire: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(switch_on) && $past(state_q == fcc_pkg::ST_OFF_WAIT) && !$past(fast_mode)
    |-> $past(off_len_q) == CNT_W'(TIMER_OFF_CYC - 1))
    else $error("timer mode off-time not exact");

  a_min_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(switch_on) && $past(state_q != fcc_pkg::ST_IDLE) &&
    $past(state_q != fcc_pkg::ST_DONE) |-> $past(off_len_q) >= MIN_LAST)
    else $error("minimum off-time violated");

  a_limit_code: assert property (@(posedge clk_sys) disable iff (!nrst)
    switch_current_limit != 2'h3)
    else $error("illegal current limit code");

  a_limit_update: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(switch_on) |-> switch_current_limit == $past(lim_code) ##1
    $stable(switch_current_limit))
    else $error("limit not taken at turn-on");

  a_req_low_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_en && !req_s |-> ##1 (!switch_on && !timer_mode && !charging && off_cnt_q == 0))
    else $error("controller not idle with request low");

endmodule
`default_nettype wire

// ==== src/fcc_pkg.sv ====
// Purpose: Shared constants and types of the flyback charge controller
// Assumes: 100 MHz system clock, analog comparators outside this logic
// Notes:   Timing counts derive from times in ns and the clock period
//
// Notes on behaviour
// - A charging sequence starts only on a rising edge of the charge request.
// - While the switch is on, it turns off at once when the current comparator trips.
// - The feedback comparator (1.205 V reference) is looked at only while the switch is off.
// - Once feedback reports target voltage, charging stops until a new rising request.
// - In fast mode the switch turns on as soon as the switch node falls below 1.2 V.
// - Timer mode is used while the output is below about 10 to 20 V, fast mode above it.
// - In timer mode the off-time is 18 us, after which the switch turns on again.
// - The switch stays off at least 300 ns before any turn-on; a start from idle here has no minimum off-time.
// - The limit select pin decodes low to 1.6 A, floating to 1.8 A, high to 2.0 A.
// - A new limit selection is taken during charging and applies from the next on-time.
package fcc_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TOFF_MIN_NS   = 300;
  localparam int TIMER_OFF_NS  = 18000;
  // Least time rounds up, fixed off-time rounds down
  localparam int TOFF_MIN_CYC  = (TOFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_OFF_CYC = TIMER_OFF_NS / CLK_PERIOD_NS;
  localparam int OFF_CNT_W     = 11;

  // ---------------------------------------------------------------
  // Current limit codes driven to the current comparator reference
  // ---------------------------------------------------------------
  localparam logic [1:0] LIM_1A6 = 2'h0;
  localparam logic [1:0] LIM_1A8 = 2'h1;
  localparam logic [1:0] LIM_2A0 = 2'h2;

  // ---------------------------------------------------------------
  // Controller states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_ON       = 5'h02,
    ST_OFF_MIN  = 5'h04,
    ST_OFF_WAIT = 5'h08,
    ST_DONE     = 5'h10
  } fcc_state_t;

endpackage

// ==== src/fcc_sync.sv ====
// Purpose: Two-flop synchroniser for asynchronous comparator and pin levels
// Assumes: Inputs are slow levels relative to clk_sys
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module fcc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // Next values, frozen while clock enable is low
  always_comb begin
    meta_d = clk_en ? async_in : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
  end

  // Register both stages
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

// ==== bench/fcc_stage_model.sv ====
// Purpose: Behavioural power stage: current sense, switch node, feedback, mode level
// Assumes: Bench sets on-time, node collapse delay and pulses to target
// Notes:   fb_pulses of zero disables feedback and clears the pulse count
`timescale 1ns/1ps
`default_nettype none
module fcc_stage_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       switch_on,
  input  wire logic       fast,
  input  wire logic [7:0] ton,
  input  wire logic [7:0] node_dly,
  input  wire logic [7:0] fb_pulses,
  output logic            current_limit_hit,
  output logic            switch_node_low,
  output logic            feedback_sense,
  output logic            vout_above_mode
);
  logic [7:0] on_cnt_q;
  logic [7:0] off_cnt_q;
  logic [7:0] pulses_q;
  logic       sw_q;

  // ---------------------------------------------------------------
  // Primary ramp, flyback and pulse counters
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    sw_q <= switch_on;
    if (!nrst || fb_pulses == 8'h00) begin
      pulses_q <= 8'h00;
    end else if (switch_on && !sw_q && pulses_q != 8'hFF) begin
      pulses_q <= pulses_q + 8'h01;
    end
    if (!nrst || !switch_on) begin
      on_cnt_q <= 8'h00;
    end else if (on_cnt_q != 8'hFF) begin
      on_cnt_q <= on_cnt_q + 8'h01;
    end
    if (!nrst || switch_on) begin
      off_cnt_q <= 8'h00;
    end else if (off_cnt_q != 8'hFF) begin
      off_cnt_q <= off_cnt_q + 8'h01;
    end
  end

  // Comparator levels seen by the controller
  assign current_limit_hit = switch_on && (on_cnt_q >= ton);
  assign switch_node_low   = switch_on || (off_cnt_q >= node_dly);
  assign feedback_sense    = !switch_on && (off_cnt_q >= 8'h02) && (fb_pulses != 8'h00)
                             && (pulses_q >= fb_pulses);
  assign vout_above_mode   = fast;
endmodule
`default_nettype wire

// ==== bench/flyback_charge_controller_tb.sv ====
// Purpose: Self-checking bench of the flyback charge controller
// Assumes: Timer-mode off-time shortened to 50 cycles
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module flyback_charge_controller_tb;
  localparam int TMR = 50;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic charge_req = 1'b0;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b0;
  logic fast = 1'b1;
  logic [7:0] ton = 8'h08;
  logic [7:0] node_dly = 8'h01;
  logic [7:0] fb_pulses = 8'h00;
  logic hit, node_low, fb, vabove, switch_on, charging, timer_mode, charge_done;
  logic [1:0] lim;
  int failures = 0;
  int n_compared = 0;
  int n;

  always #5 clk_sys = ~clk_sys;

  fcc_ctrl #(.TIMER_OFF_CYC(TMR)) fcc_ctrl_i (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
    .charge_req(charge_req), .current_limit_hit(hit), .switch_node_low(node_low),
    .feedback_sense(fb), .vout_above_mode(vabove), .current_limit_select_low(sel_lo),
    .current_limit_select_high(sel_hi), .switch_on(switch_on), .switch_current_limit(lim),
    .charging(charging), .timer_mode(timer_mode), .charge_done(charge_done));
  fcc_stage_model fcc_stage_model_i (.clk_sys(clk_sys), .nrst(nrst), .switch_on(switch_on),
    .fast(fast), .ton(ton), .node_dly(node_dly), .fb_pulses(fb_pulses),
    .current_limit_hit(hit), .switch_node_low(node_low), .feedback_sense(fb),
    .vout_above_mode(vabove));

  // ---------------------------------------------------------------
  // Compare, wait and closing tasks
  // ---------------------------------------------------------------
  task automatic chk_b(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_v(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_n(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      failures++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_sw(input logic lvl, output int c);
    c = 0;
    while (switch_on !== lvl && c < 3000) begin
      cyc(1);
      c++;
    end
    if (c >= 3000) begin
      failures++;
      $display("Error wait_switch expected %0h seen %0h", lvl, switch_on);
    end
  endtask
  task automatic stop_req();
    charge_req = 1'b0;
    fb_pulses = 8'h00;
    cyc(6);
  endtask
  task automatic summarize();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk_b("switch_on", 1'b0, switch_on);
    chk_b("charging", 1'b0, charging);
    chk_b("charge_done", 1'b0, charge_done);
    chk_b("timer_mode", 1'b0, timer_mode);
    chk_v("limit", fcc_pkg::LIM_1A8, lim);
    $display("Test reset done");
  endtask
  task automatic t_limit();
    logic [1:0] exp [4];
    logic [1:0] prev;
    exp = '{fcc_pkg::LIM_2A0, fcc_pkg::LIM_1A8, fcc_pkg::LIM_1A6, fcc_pkg::LIM_1A8};
    charge_req = 1'b1;
    wait_sw(1'b1, n);
    for (int i = 0; i < 4; i++) begin
      prev = (i == 0) ? fcc_pkg::LIM_1A8 : exp[i - 1];
      sel_hi = (i < 2);
      sel_lo = (i == 1) || (i == 2);
      cyc(1);
      chk_v("limit_hold", prev, lim);
      repeat (2) begin
        wait_sw(1'b0, n);
        wait_sw(1'b1, n);
      end
      chk_v("limit_sel", exp[i], lim);
    end
    stop_req();
    $display("Test limit done");
  endtask
  task automatic t_fast();
    logic seen;
    fb_pulses = 8'h03;
    charge_req = 1'b1;
    wait_sw(1'b1, n);
    chk_b("start_lat", 1'b1, n <= 4);
    chk_b("charging", 1'b1, charging);
    wait_sw(1'b0, n);
    chk_b("on_time", 1'b1, n >= 7 && n <= 12);
    wait_sw(1'b1, n);
    chk_b("off_min", 1'b1, n >= 30);
    chk_b("fast_on", 1'b1, n <= 36);
    cyc(150);
    chk_b("done", 1'b1, charge_done);
    chk_b("charging_end", 1'b0, charging);
    seen = 1'b0;
    repeat (100) begin
      cyc(1);
      seen = seen | (switch_on !== 1'b0);
    end
    chk_b("no_restart", 1'b0, seen);
    charge_req = 1'b0;
    cyc(6);
    charge_req = 1'b1;
    wait_sw(1'b1, n);
    chk_b("refresh", 1'b1, charging);
    wait_sw(1'b0, n);
    chk_b("fb_on_ignored", 1'b1, n >= 7);
    cyc(10);
    chk_b("refresh_done", 1'b1, charge_done);
    stop_req();
    charge_req = 1'b1;
    wait_sw(1'b1, n);
    chk_b("restart", 1'b1, charging);
    cyc(20);
    charge_req = 1'b0;
    cyc(5);
    chk_b("drop_sw", 1'b0, switch_on);
    chk_b("drop_chg", 1'b0, charging);
    cyc(2);
    $display("Test fast done");
  endtask
  task automatic t_timer();
    fast = 1'b0;
    node_dly = 8'hFF;
    charge_req = 1'b1;
    wait_sw(1'b1, n);
    cyc(2);
    chk_b("timer_mode", 1'b1, timer_mode);
    wait_sw(1'b0, n);
    wait_sw(1'b1, n);
    chk_n("timer_off", TMR, n);
    fast = 1'b1;
    node_dly = 8'h01;
    repeat (2) begin
      wait_sw(1'b0, n);
      wait_sw(1'b1, n);
    end
    chk_b("fast_mode", 1'b0, timer_mode);
    chk_b("fast_off", 1'b1, n >= 30 && n <= 36);
    charge_req = 1'b0;
    cyc(5);
    chk_b("timer_idle", 1'b0, timer_mode);
    $display("Test timer done");
  endtask
  task automatic t_freeze();
    fast = 1'b1;
    charge_req = 1'b1;
    wait_sw(1'b1, n);
    clk_en = 1'b0;
    cyc(40);
    chk_b("frozen_on", 1'b1, switch_on);
    chk_b("frozen_chg", 1'b1, charging);
    clk_en = 1'b1;
    wait_sw(1'b0, n);
    chk_n("thaw_off", 3, n);
    charge_req = 1'b0;
    cyc(5);
    chk_b("freeze_idle", 1'b0, charging);
    $display("Test freeze done");
  endtask

  initial begin
    cyc(10);
    nrst = 1'b1;
    cyc(2);
    t_reset();
    t_limit();
    t_fast();
    t_timer();
    t_freeze();
    summarize();
  end

  // Watchdog: tests need well under 5000 cycles
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
